// *** rtl/pdf_pkg.sv ***
/*
  pdf_pkg: shared constants for the periodic descriptor field block.
  The register offsets, the field positions and the reset values live here.
  It assumes a 32-bit plain register port with byte addresses.
*/
package pdf_pkg;
  localparam int PDF_ADDR_W = 5;
  localparam int PDF_DATA_W = 32;
  localparam int PDF_UFRAMES = 8;
  localparam int PDF_CNT_W = 12;
  localparam int PDF_RES_W = 3;
  localparam int PDF_BC_W = 15;
  localparam int PDF_FRM_W = 5;
  localparam int PDF_IRQ_W = 3;

  // byte offsets of the word registers
  localparam logic [PDF_ADDR_W-1:0] PDF_OFF_DESC = 5'h00;
  localparam logic [PDF_ADDR_W-1:0] PDF_OFF_SCHED = 5'h04;
  localparam logic [PDF_ADDR_W-1:0] PDF_OFF_RESULT = 5'h08;
  localparam logic [PDF_ADDR_W-1:0] PDF_OFF_COUNT = 5'h0c;
  localparam logic [PDF_ADDR_W-1:0] PDF_OFF_IRQ_STAT = 5'h10;
  localparam logic [PDF_ADDR_W-1:0] PDF_OFF_IRQ_MASK = 5'h14;

  // descriptor word fields
  localparam int PDF_VALID_BIT = 0;
  localparam int PDF_BC_LSB = 3;
  localparam int PDF_BC_MSB = 17;
  // scheduling word fields
  localparam int PDF_FRM_LSB = 3;
  localparam int PDF_FRM_MSB = 7;
  localparam int PDF_MASK_LSB = 8;
  localparam int PDF_MASK_MSB = 15;
  // count word: upper half of the 64-bit descriptor word, so 63:52 and 51:40
  localparam int PDF_CNT7_LSB = 20;
  localparam int PDF_CNT7_MSB = 31;
  localparam int PDF_CNT6_LSB = 8;
  localparam int PDF_CNT6_MSB = 19;
  localparam logic [2:0] PDF_UF6 = 3'h6;
  localparam logic [2:0] PDF_UF7 = 3'h7;

  // interrupt status bits
  localparam int PDF_IRQ_DONE = 0;
  localparam int PDF_IRQ_FATAL = 1;
  localparam int PDF_IRQ_RESULT = 2;

  localparam logic [PDF_DATA_W-1:0] PDF_ZERO_WORD = 32'h0000_0000;
  localparam logic [PDF_IRQ_W-1:0] PDF_IRQ_RST = 3'h0;
endpackage

// *** rtl/pdf_slot_gate.sv ***
/*
  pdf_slot_gate: decides which microframe slot may take a result.
  It assumes the inputs are synchronous to the core clock and that the
  caller registers everything it derives from the hit vector.
*/
`timescale 1ns/1ps
module pdf_slot_gate
  import pdf_pkg::*;
#(
  parameter int UFRAMES = PDF_UFRAMES
)
(
  input wire logic valid_in,
  input wire logic uf_done_in,
  input wire logic [2:0] uf_index_in,
  input wire logic [UFRAMES-1:0] act_mask_in,
  input wire logic [PDF_FRM_W-1:0] frame_want_in,
  input wire logic [PDF_FRM_W-1:0] frame_now_in,
  output logic [UFRAMES-1:0] hit_out
);
  logic base_ok;

  // an inactive descriptor or a wrong frame takes nothing at all
  assign base_ok = uf_done_in & valid_in & (frame_want_in == frame_now_in);

  // one gate per slot: its own activation bit and its own index
  for (genvar i = 0; i < UFRAMES; i++)
  begin : g_slot
    assign hit_out[i] = base_ok & act_mask_in[i] & (uf_index_in == 3'(i));
  end
endmodule

// *** rtl/pdf_fields.sv ***
/*
  pdf_fields: holds one periodic transfer descriptor's control fields,
  its per-microframe result codes and the microframe 6 and 7 byte counts,
  with a register port, sticky events and one level interrupt.
  It assumes the scheduling engine gives one-cycle pulses synchronous to
  ref_clk_in and that software never asserts both strobes at once.
*/
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Function
// - hardware clears valid after full execution
// - hardware clears valid on fatal error
// - microframe 7 byte count into 63:52
// - microframe 6 byte count into 51:40
// - each microframe result in own 3-bit field
module pdf_fields
  import pdf_pkg::*;
#(
  parameter int UFRAMES = PDF_UFRAMES
)
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [PDF_ADDR_W-1:0] addr_in,
  input wire logic [PDF_DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic uf_done_in,
  input wire logic [2:0] uf_index_in,
  input wire logic [PDF_FRM_W-1:0] frame_now_in,
  input wire logic [PDF_CNT_W-1:0] rx_bytes_in,
  input wire logic [PDF_RES_W-1:0] result_code_in,
  input wire logic desc_done_in,
  input wire logic fatal_err_in,
  output logic [PDF_DATA_W-1:0] rd_data_out,
  output logic desc_active_out,
  output logic [PDF_BC_W-1:0] requested_byte_count_out,
  output logic [UFRAMES-1:0] uframe_activation_mask_out,
  output logic [PDF_FRM_W-1:0] frame_want_out,
  output logic irq_out
);
  typedef struct packed {
    logic valid;
    logic [PDF_BC_W-1:0] byte_count;
    logic [PDF_FRM_W-1:0] frame;
    logic [UFRAMES-1:0] act_mask;
    logic [UFRAMES*PDF_RES_W-1:0] result;
    logic [PDF_CNT_W-1:0] cnt7;
    logic [PDF_CNT_W-1:0] cnt6;
    logic [PDF_IRQ_W-1:0] irq_stat;
    logic [PDF_IRQ_W-1:0] irq_mask;
    logic irq;
    logic [PDF_DATA_W-1:0] rdata;
  } pdf_state_s;

  pdf_state_s st_q;
  pdf_state_s st_d;
  logic [UFRAMES-1:0] hit;
  logic wr_desc;
  logic hw_end;
  logic [PDF_IRQ_W-1:0] events;
  logic irq_stat_fatal;

  pdf_slot_gate #(
    .UFRAMES(UFRAMES)
  ) u_gate (
    .valid_in(st_q.valid),
    .uf_done_in(uf_done_in),
    .uf_index_in(uf_index_in),
    .act_mask_in(st_q.act_mask),
    .frame_want_in(st_q.frame),
    .frame_now_in(frame_now_in),
    .hit_out(hit)
  );

  assign wr_desc = wr_en_in & (addr_in == PDF_OFF_DESC);
  // done or fatal only matter while the descriptor is live
  assign hw_end = st_q.valid & (desc_done_in | fatal_err_in);
  assign events = {|hit, st_q.valid & fatal_err_in, st_q.valid & desc_done_in};

  // next state: bus writes, engine updates, sticky events, read data
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = PDF_ZERO_WORD;
    // a fresh software write wins over the end of the previous run
    if (hw_end)
    begin
      st_d.valid = 1'b0;
    end
    if (wr_en_in)
    begin
      if (addr_in == PDF_OFF_DESC)
      begin
        st_d.valid = wr_data_in[PDF_VALID_BIT];
        st_d.byte_count = wr_data_in[PDF_BC_MSB:PDF_BC_LSB];
      end
      else if (addr_in == PDF_OFF_SCHED)
      begin
        st_d.frame = wr_data_in[PDF_FRM_MSB:PDF_FRM_LSB];
        st_d.act_mask = wr_data_in[PDF_MASK_MSB:PDF_MASK_LSB];
      end
      else if (addr_in == PDF_OFF_IRQ_MASK)
      begin
        st_d.irq_mask = wr_data_in[PDF_IRQ_W-1:0];
      end
    end
    // result fields, one 3-bit slot per microframe
    for (int i = 0; i < UFRAMES; i++)
    begin
      if (hit[i])
      begin
        st_d.result[i*PDF_RES_W +: PDF_RES_W] = result_code_in;
      end
    end
    if (hit[PDF_UF7])
    begin
      st_d.cnt7 = rx_bytes_in;
    end
    if (hit[PDF_UF6])
    begin
      st_d.cnt6 = rx_bytes_in;
    end
    // read port; unmapped offsets answer zero
    if (rd_en_in)
    begin
      if (addr_in == PDF_OFF_DESC)
      begin
        st_d.rdata[PDF_VALID_BIT] = st_q.valid;
        st_d.rdata[PDF_BC_MSB:PDF_BC_LSB] = st_q.byte_count;
      end
      else if (addr_in == PDF_OFF_SCHED)
      begin
        st_d.rdata[PDF_FRM_MSB:PDF_FRM_LSB] = st_q.frame;
        st_d.rdata[PDF_MASK_MSB:PDF_MASK_LSB] = st_q.act_mask;
      end
      else if (addr_in == PDF_OFF_RESULT)
      begin
        st_d.rdata[UFRAMES*PDF_RES_W-1:0] = st_q.result;
      end
      else if (addr_in == PDF_OFF_COUNT)
      begin
        st_d.rdata[PDF_CNT7_MSB:PDF_CNT7_LSB] = st_q.cnt7;
        st_d.rdata[PDF_CNT6_MSB:PDF_CNT6_LSB] = st_q.cnt6;
      end
      else if (addr_in == PDF_OFF_IRQ_STAT)
      begin
        st_d.rdata[PDF_IRQ_W-1:0] = st_q.irq_stat;
      end
      else if (addr_in == PDF_OFF_IRQ_MASK)
      begin
        st_d.rdata[PDF_IRQ_W-1:0] = st_q.irq_mask;
      end
    end
    // read clears the sticky bits, but an event in the same cycle survives
    if (rd_en_in && (addr_in == PDF_OFF_IRQ_STAT))
    begin
      st_d.irq_stat = PDF_IRQ_RST;
    end
    st_d.irq_stat = st_d.irq_stat | events;
    // registered from the next state so the pin never glitches; rises in the same cycle as the status bit
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      st_q <= '0;
    end
    else if (ce_in)
    begin
      st_q <= st_d;
    end
  end

  assign rd_data_out = st_q.rdata;
  assign desc_active_out = st_q.valid;
  assign requested_byte_count_out = st_q.byte_count;
  assign uframe_activation_mask_out = st_q.act_mask;
  assign frame_want_out = st_q.frame;
  assign irq_out = st_q.irq;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  chk_done_clears_valid: assert property (
    ce_in && st_q.valid && desc_done_in && !wr_desc |=> !desc_active_out)
    else $error("valid not cleared after descriptor done");

  chk_fatal_clears_valid: assert property (
    ce_in && st_q.valid && fatal_err_in && !wr_desc |=> !desc_active_out ##0 irq_stat_fatal)
    else $error("valid not cleared or fatal not flagged");

  chk_count7_written: assert property (
    ce_in && st_q.valid && st_q.act_mask[PDF_UF7] && uf_done_in && uf_index_in == PDF_UF7
      && frame_now_in == st_q.frame |=> st_q.cnt7 == $past(rx_bytes_in))
    else $error("microframe 7 count not written");

  chk_count6_written: assert property (
    ce_in && st_q.valid && st_q.act_mask[PDF_UF6] && uf_done_in && uf_index_in == PDF_UF6
      && frame_now_in == st_q.frame |=> st_q.cnt6 == $past(rx_bytes_in))
    else $error("microframe 6 count not written");

  chk_result7_slot: assert property (
    ce_in && hit[PDF_UF7] |=> st_q.result[UFRAMES*PDF_RES_W-1 -: PDF_RES_W]
      == $past(result_code_in))
    else $error("microframe 7 result code misplaced");

  chk_skip_inactive: assert property (
    !st_q.valid |=> $stable(st_q.cnt7) && $stable(st_q.cnt6) && $stable(st_q.result))
    else $error("inactive descriptor fields changed");

  // fatal status bit, named so the fatal check reads plainly
  assign irq_stat_fatal = st_q.irq_stat[PDF_IRQ_FATAL];
endmodule

// *** rtl/pdf_fields_note_unused.sv ***
/*
  pdf_fields_note_unused: holds no logic; the field block lives in pdf_fields.
  It assumes nothing of its surroundings.
*/

// *** testbench/pdf_host_model.sv ***
/*
  pdf_host_model: software side of the descriptor register port.
  Assumes one bench process calls its tasks, clocked by ref_clk_in.
*/
`timescale 1ns/1ps
module pdf_host_model
  import pdf_pkg::*;
(
  input wire logic clk_in,
  input wire logic [PDF_DATA_W-1:0] rd_data_in,
  output logic [PDF_ADDR_W-1:0] addr_out,
  output logic [PDF_DATA_W-1:0] wr_data_out,
  output logic wr_en_out,
  output logic rd_en_out
);
  // strobes low from time zero
  initial
  begin
    addr_out = 5'h00;
    wr_data_out = 32'h0000_0000;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  // byte count at 17:3, valid at bit 0; payload location stays with software
  function automatic logic [PDF_DATA_W-1:0] desc_word(input logic [PDF_BC_W-1:0] bc,
    input logic v);
    desc_word = {14'h0, bc, 2'h0, v};
  endfunction

  // released lines flip so a stale value is never mistaken for a live one
  task automatic wr_reg(input logic [PDF_ADDR_W-1:0] a, input logic [PDF_DATA_W-1:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [PDF_ADDR_W-1:0] a, output logic [PDF_DATA_W-1:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rd_data_in;
  endtask
endmodule

// *** testbench/pdf_fields_tb.sv ***
/*
  pdf_fields_tb: register sequences and engine pulses with expected words.
  Assumes pdf_fields and pdf_host_model; ce_in stays high except around the final irq mask write.
*/
`timescale 1ns/1ps
module pdf_fields_tb
  import pdf_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [PDF_ADDR_W-1:0] addr;
  logic [PDF_DATA_W-1:0] wdata, rdata;
  logic wr_en, rd_en, irq, active;
  logic uf_done = 1'b0;
  logic [2:0] uf_index = 3'h0;
  logic [PDF_FRM_W-1:0] frame_now = 5'h00;
  logic [PDF_CNT_W-1:0] rx_bytes = 12'h000;
  logic [PDF_RES_W-1:0] result_code = 3'h0;
  logic desc_done = 1'b0;
  logic fatal_err = 1'b0;
  logic [PDF_BC_W-1:0] bc;
  logic ce = 1'b1;
  logic [PDF_UFRAMES-1:0] act_mask;
  logic [PDF_FRM_W-1:0] frame_want;
  int fails = 0;
  int n_tests = 0;

  // 100 MHz core clock
  initial
  begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  pdf_host_model u_host (.clk_in(ref_clk_in), .rd_data_in(rdata), .addr_out(addr),
    .wr_data_out(wdata), .wr_en_out(wr_en), .rd_en_out(rd_en));

  pdf_fields u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .uf_done_in(uf_done), .uf_index_in(uf_index), .frame_now_in(frame_now),
    .rx_bytes_in(rx_bytes), .result_code_in(result_code), .desc_done_in(desc_done),
    .fatal_err_in(fatal_err), .rd_data_out(rdata), .desc_active_out(active),
    .requested_byte_count_out(bc), .uframe_activation_mask_out(act_mask),
    .frame_want_out(frame_want), .irq_out(irq));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic w(input logic [PDF_ADDR_W-1:0] a, input logic [PDF_DATA_W-1:0] d);
    u_host.wr_reg(a, d);
    #1;
  endtask

  task automatic rchk(input logic [PDF_ADDR_W-1:0] a, input logic [PDF_DATA_W-1:0] e);
    logic [PDF_DATA_W-1:0] v;
    u_host.rd_reg(a, v);
    chk(v, e);
  endtask

  // one-cycle engine result; the byte lines flip once the pulse ends
  task automatic eng(input logic [2:0] i, input logic [4:0] f, input logic [11:0] b,
    input logic [2:0] c);
    @(posedge ref_clk_in);
    uf_done <= 1'b1;
    uf_index <= i;
    frame_now <= f;
    rx_bytes <= b;
    result_code <= c;
    @(posedge ref_clk_in);
    uf_done <= 1'b0;
    rx_bytes <= ~b;
    #1;
  endtask

  // one-cycle done (sel high) or fatal pulse
  task automatic pulse(input logic sel);
    @(posedge ref_clk_in);
    desc_done <= sel;
    fatal_err <= ~sel;
    @(posedge ref_clk_in);
    desc_done <= 1'b0;
    fatal_err <= 1'b0;
    #1;
  endtask

  // a hang is cut short well inside the cycle budget
  initial
  begin
    #200000;
    fails++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rchk(PDF_OFF_DESC, 32'h0000_0000);
    w(PDF_OFF_DESC, u_host.desc_word(15'h7fff, 1'b1));
    chk({17'h0, bc}, 32'h0000_7fff);
    chk({31'h0, active}, 32'h0000_0001);
    rchk(PDF_OFF_DESC, 32'h0003_fff9);
    w(PDF_OFF_SCHED, 32'h0000_c028);
    chk({24'h0, act_mask}, 32'h0000_00c0);
    chk({27'h0, frame_want}, 32'h0000_0005);
    rchk(PDF_OFF_SCHED, 32'h0000_c028);
    w(PDF_OFF_IRQ_MASK, 32'h0000_0007);
    rchk(PDF_OFF_IRQ_MASK, 32'h0000_0007);
    eng(3'h7, 5'h05, 12'habc, 3'h5);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(PDF_OFF_COUNT, 32'habc0_0000);
    rchk(PDF_OFF_RESULT, 32'h00a0_0000);
    eng(3'h6, 5'h05, 12'h123, 3'h3);
    rchk(PDF_OFF_COUNT, 32'habc1_2300);
    rchk(PDF_OFF_RESULT, 32'h00ac_0000);
    // wrong frame, then a slot whose activation bit is clear
    eng(3'h7, 5'h04, 12'hfff, 3'h7);
    eng(3'h5, 5'h05, 12'hfff, 3'h7);
    rchk(PDF_OFF_COUNT, 32'habc1_2300);
    rchk(PDF_OFF_RESULT, 32'h00ac_0000);
    rchk(PDF_OFF_IRQ_STAT, 32'h0000_0004);
    rchk(PDF_OFF_IRQ_STAT, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    pulse(1'b1);
    chk({31'h0, active}, 32'h0000_0000);
    rchk(PDF_OFF_IRQ_STAT, 32'h0000_0001);
    // inactive descriptor takes no result
    eng(3'h7, 5'h05, 12'h001, 3'h1);
    rchk(PDF_OFF_COUNT, 32'habc1_2300);
    rchk(PDF_OFF_IRQ_STAT, 32'h0000_0000);
    w(PDF_OFF_DESC, u_host.desc_word(15'h0001, 1'b1));
    pulse(1'b0);
    chk({31'h0, active}, 32'h0000_0000);
    rchk(PDF_OFF_IRQ_STAT, 32'h0000_0002);
    // read-only and unmapped places
    w(PDF_OFF_COUNT, 32'hffff_ffff);
    rchk(PDF_OFF_COUNT, 32'habc1_2300);
    rchk(5'h1c, 32'h0000_0000);
    // clock enable low: a mask write must leave no trace
    @(posedge ref_clk_in);
    ce <= 1'b0;
    w(PDF_OFF_IRQ_MASK, 32'h0000_0000);
    @(posedge ref_clk_in);
    ce <= 1'b1;
    rchk(PDF_OFF_IRQ_MASK, 32'h0000_0007);
    final_report();
  end
endmodule
